// file: rtl/irtc_ctrl.sv
// common control of the narrow and wide counter/timers
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module irtc_ctrl
  import irtc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // supply comparator and stop recovery
  input wire logic supply_low_i,
  input wire logic stop_recover_i,
  output logic sys_rst_n_o,
  // timer datapath side
  input wire logic narrow_timer_raw_i,
  input wire logic wide_timer_raw_i,
  input wire logic port_data_i,
  output logic narrow_timer_init_o,
  output logic wide_timer_init_o,
  output logic pingpong_o,
  output logic demod_mode_o,
  output logic wide_timer_output_o,
  output logic timer_output_pin_o,
  // demodulator pins and events
  input wire logic comparator_capture_pin_i,
  input wire logic alternate_capture_pin_i,
  output logic capture_o,
  output logic shared_external_interrupt_o
);

  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic bo_low_s;
  logic [POR_CW-1:0] por_cnt_ff;
  logic rst_hold_ff;
  logic [7:0] ctl_ff;
  logic [7:0] wide_ctl_ff;
  logic init_wide_ff;
  logic init_narrow_ff;
  logic fall_flag_ff;
  logic rise_flag_ff;
  logic filt_ff;
  logic [3:0] filt_cnt_ff;
  logic rise_ev;
  logic fall_ev;
  logic cap_ev;
  logic sel_in_s;
  logic demod;
  logic [1:0] sub_sel;
  logic [1:0] func_sel;
  logic [3:0] filt_len;
  logic combined;
  logic ctl_wr;
  logic nxt_filt;
  logic [7:0] nxt_rdata;

  assign demod = ctl_ff[BIT_MODE];
  assign sub_sel = ctl_ff[BIT_SUB_HI:BIT_SUB_LO];
  assign func_sel = ctl_ff[BIT_FUNC_HI:BIT_FUNC_LO];
  assign ctl_wr = wr_i && (addr_i == ADDR_COMMON_CTL);

  // pins cross into the clock domain through two flops
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
    end
    else
    begin
      sync1_ff <= {alternate_capture_pin_i, comparator_capture_pin_i, supply_low_i};
      sync2_ff <= sync1_ff;
    end
  end
  assign bo_low_s = sync2_ff[0];

  assign sel_in_s = ctl_ff[BIT_ROUTE] ? sync2_ff[2] : sync2_ff[1];

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      por_cnt_ff <= '0;
      rst_hold_ff <= 1'b1;
    end
    else if (bo_low_s)
    begin
      por_cnt_ff <= '0;
      rst_hold_ff <= 1'b1;
    end
    else if (rst_hold_ff)
    begin
      por_cnt_ff <= por_cnt_ff + POR_CW'(1);
      rst_hold_ff <= (por_cnt_ff != POR_CW'(POR_CYCLES - 1));
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      sys_rst_n_o <= 1'b0;
    else
      sys_rst_n_o <= !rst_hold_ff && !bo_low_s;
  end

  // mode and stored fields; D1:D0 are shadowed elsewhere
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ctl_ff <= COMMON_CTL_RST;
    else if (rst_hold_ff)
      ctl_ff <= COMMON_CTL_RST;
    else if (stop_recover_i)
      ctl_ff <= (ctl_ff & ~STOP_RELOAD_MASK) | (COMMON_CTL_RST & STOP_RELOAD_MASK);
    else if (ctl_wr)
      ctl_ff <= wdata_i;
  end

  // wide timer control layout lives in the timer itself; stored here only
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      wide_ctl_ff <= WIDE_CTL_RST;
    else if (rst_hold_ff)
      wide_ctl_ff <= WIDE_CTL_RST;
    else if (wr_i && (addr_i == ADDR_WIDE_CTL))
      wide_ctl_ff <= wdata_i;
  end

  // initial levels only take writes in transmit mode
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      init_wide_ff <= COMMON_CTL_RST[BIT_INIT_WIDE];
      init_narrow_ff <= COMMON_CTL_RST[BIT_INIT_NARROW];
    end
    else if (rst_hold_ff)
    begin
      init_wide_ff <= COMMON_CTL_RST[BIT_INIT_WIDE];
      init_narrow_ff <= COMMON_CTL_RST[BIT_INIT_NARROW];
    end
    else if (stop_recover_i)
      init_wide_ff <= COMMON_CTL_RST[BIT_INIT_WIDE];
    else if (ctl_wr && !demod)
    begin
      init_wide_ff <= wdata_i[BIT_INIT_WIDE];
      init_narrow_ff <= wdata_i[BIT_INIT_NARROW];
    end
  end

  always_comb
  begin
    case (sub_sel)
      FILT_4: filt_len = FILT_LEN_4;
      FILT_8: filt_len = FILT_LEN_8;
      default: filt_len = 4'h0;
    endcase
  end

  // input must differ for the whole length before it is taken
  assign nxt_filt = (sel_in_s != filt_ff) && ((filt_cnt_ff + 4'h1) >= filt_len) ? sel_in_s : filt_ff;
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      filt_ff <= 1'b0;
      filt_cnt_ff <= 4'h0;
    end
    else
    begin
      filt_ff <= nxt_filt;
      if ((sel_in_s == filt_ff) || (nxt_filt != filt_ff))
        filt_cnt_ff <= 4'h0;
      else
        filt_cnt_ff <= filt_cnt_ff + 4'h1;
    end
  end

  assign rise_ev = demod && !filt_ff && nxt_filt && ((func_sel == EDGE_RISE) || (func_sel == EDGE_BOTH));
  assign fall_ev = demod && filt_ff && !nxt_filt && ((func_sel == EDGE_FALL) || (func_sel == EDGE_BOTH));
  assign cap_ev = rise_ev || fall_ev;

  // edge flags: a new edge beats a same-cycle clear
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      fall_flag_ff <= 1'b0;
      rise_flag_ff <= 1'b0;
    end
    else if (rst_hold_ff)
    begin
      fall_flag_ff <= 1'b0;
      rise_flag_ff <= 1'b0;
    end
    else
    begin
      if (fall_ev)
        fall_flag_ff <= 1'b1;
      else if (ctl_wr && demod && wdata_i[BIT_INIT_WIDE])
        fall_flag_ff <= 1'b0;
      if (rise_ev)
        rise_flag_ff <= 1'b1;
      else if (ctl_wr && demod && wdata_i[BIT_INIT_NARROW])
        rise_flag_ff <= 1'b0;
    end
  end

  always_comb
  begin
    case (func_sel)
      FUNC_AND: combined = narrow_timer_raw_i & wide_timer_raw_i;
      FUNC_OR: combined = narrow_timer_raw_i | wide_timer_raw_i;
      FUNC_NOR: combined = !(narrow_timer_raw_i | wide_timer_raw_i);
      default: combined = !(narrow_timer_raw_i & wide_timer_raw_i);
    endcase
  end

  // read data only in the cycle after the strobe
  always_comb
  begin
    nxt_rdata = 8'h00;
    if (rd_i && (addr_i == ADDR_COMMON_CTL))
    begin
      nxt_rdata = ctl_ff;
      if (demod)
        nxt_rdata[BIT_INIT_NARROW:BIT_INIT_WIDE] = {rise_flag_ff, fall_flag_ff};
      else
        nxt_rdata[BIT_INIT_NARROW:BIT_INIT_WIDE] = {init_narrow_ff, init_wide_ff};
    end
    else if (rd_i && (addr_i == ADDR_WIDE_CTL))
      nxt_rdata = wide_ctl_ff;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_o <= 8'h00;
    else
      rdata_o <= nxt_rdata;
  end

  // timer side outputs
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      narrow_timer_init_o <= 1'b0;
      wide_timer_init_o <= 1'b0;
      pingpong_o <= 1'b0;
      demod_mode_o <= 1'b0;
      wide_timer_output_o <= 1'b0;
      timer_output_pin_o <= 1'b0;
    end
    else
    begin
      narrow_timer_init_o <= init_narrow_ff;
      wide_timer_init_o <= init_wide_ff;
      pingpong_o <= !demod && (sub_sel == SUB_PINGPONG);
      demod_mode_o <= demod;
      if (!demod && (sub_sel == SUB_FORCE0))
        wide_timer_output_o <= 1'b0;
      else if (!demod && (sub_sel == SUB_FORCE1))
        wide_timer_output_o <= 1'b1;
      else
        wide_timer_output_o <= wide_timer_raw_i;
      timer_output_pin_o <= (!demod && ctl_ff[BIT_ROUTE]) ? combined : port_data_i;
    end
  end

  // capture pulse and shared interrupt
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      capture_o <= 1'b0;
      shared_external_interrupt_o <= 1'b0;
    end
    else
    begin
      capture_o <= cap_ev;
      // comparator pin raises the shared interrupt
      shared_external_interrupt_o <= cap_ev && !ctl_ff[BIT_ROUTE];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_supply_back;
    $past(bo_low_s) && !bo_low_s;
  endsequence

  sequence s_held_then_release;
    !sys_rst_n_o ##1 sys_rst_n_o;
  endsequence

  chk_fall_set: assert property (fall_ev && !rst_hold_ff |=> fall_flag_ff)
    else $error("falling edge did not set flag");
  chk_fall_clear: assert property (ctl_wr && demod && wdata_i[0] && !fall_ev && !rst_hold_ff
    |=> !fall_flag_ff)
    else $error("falling flag not cleared by write one");
  chk_rise_set: assert property (rise_ev && !rst_hold_ff |=> rise_flag_ff)
    else $error("rising edge did not set flag");
  chk_rise_keep: assert property (ctl_wr && demod && !wdata_i[1] && rise_flag_ff && !rst_hold_ff
    |=> rise_flag_ff)
    else $error("writing zero changed rising flag");
  chk_force_low: assert property (!demod && sub_sel == SUB_FORCE0 |=> !wide_timer_output_o)
    else $error("wide output not forced low");
  chk_pin_route: assert property (!demod && ctl_ff[6] |=> timer_output_pin_o == $past(combined))
    else $error("pin not driven by combined output");
  chk_bo_reset: assert property (bo_low_s |=> !sys_rst_n_o)
    else $error("reset not held in brown-out");
  chk_por_length: assert property ($rose(sys_rst_n_o) |-> $past(por_cnt_ff, 2) == POR_CW'(POR_CYCLES - 1))
    else $error("power-on sequence length wrong");
  chk_por_start: assert property (s_supply_back |-> ##1 s_held_then_release or ##1 !sys_rst_n_o)
    else $error("reset released without sequence");
  chk_irq_source: assert property (shared_external_interrupt_o |-> capture_o && !$past(ctl_ff[6]))
    else $error("interrupt from wrong source");
  chk_mode_read: assert property (rd_i && addr_i == ADDR_COMMON_CTL && !demod
    |=> rdata_o[1:0] == $past({init_narrow_ff, init_wide_ff}))
    else $error("transmit read of initial levels wrong");
  chk_no_filter: assert property (demod && sub_sel == FILT_NONE && sel_in_s != filt_ff
    |=> filt_ff == $past(sel_in_s))
    else $error("unfiltered input not followed");

endmodule // irtc_ctrl

// file: rtl/irtc_pkg.sv
// constants for the timer common control block
package irtc_pkg;
  // register map (byte offsets on the plain register port)
  localparam logic [7:0] ADDR_COMMON_CTL = 8'h01;
  localparam logic [7:0] ADDR_WIDE_CTL = 8'h02;
  // common control field positions
  localparam int BIT_INIT_WIDE = 0;
  localparam int BIT_INIT_NARROW = 1;
  localparam int BIT_SUB_LO = 2;
  localparam int BIT_SUB_HI = 3;
  localparam int BIT_FUNC_LO = 4;
  localparam int BIT_FUNC_HI = 5;
  localparam int BIT_ROUTE = 6;
  localparam int BIT_MODE = 7;
  // power-on defaults
  localparam logic [7:0] COMMON_CTL_RST = 8'h00;
  localparam logic [7:0] WIDE_CTL_RST = 8'h00;
  // bits reloaded by a stop-mode recovery (1 = reloaded)
  localparam logic [7:0] STOP_RELOAD_MASK = 8'hF1;
  // transmit submodes
  localparam logic [1:0] SUB_NORMAL = 2'h0;
  localparam logic [1:0] SUB_PINGPONG = 2'h1;
  localparam logic [1:0] SUB_FORCE0 = 2'h2;
  localparam logic [1:0] SUB_FORCE1 = 2'h3;
  // output combine functions
  localparam logic [1:0] FUNC_AND = 2'h0;
  localparam logic [1:0] FUNC_OR = 2'h1;
  localparam logic [1:0] FUNC_NOR = 2'h2;
  localparam logic [1:0] FUNC_NAND = 2'h3;
  // demodulation glitch filter codes and lengths in clock cycles
  localparam logic [1:0] FILT_NONE = 2'h0;
  localparam logic [1:0] FILT_4 = 2'h1;
  localparam logic [1:0] FILT_8 = 2'h2;
  localparam logic [3:0] FILT_LEN_4 = 4'h4;
  localparam logic [3:0] FILT_LEN_8 = 4'h8;
  // capture edge codes
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  // power-on sequence timing
  localparam int CLK_MHZ = 50;
  localparam int POR_TIME_NS = 1000;
  localparam int POR_CYCLES = (POR_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int POR_CW = 8;
endpackage

// file: test/irtc_carrier.sv
// carrier source model driving the two demodulator pins
`timescale 1ns/1ps
module irtc_carrier
(
  // clock
  input wire logic clk_i,
  // commanded carrier level and pin choice
  input wire logic level_i,
  input wire logic use_alt_i,
  // demodulator pins
  output logic comparator_capture_pin_o,
  output logic alternate_capture_pin_o
);
  logic noise_ff = 1'b0;
  always @(posedge clk_i)
    noise_ff <= ~noise_ff;
  // unused pin keeps toggling
  // so a wrong source choice shows up as extra captures
  assign comparator_capture_pin_o = use_alt_i ? noise_ff : level_i;
  assign alternate_capture_pin_o = use_alt_i ? level_i : noise_ff;
endmodule // irtc_carrier

// file: test/irtc_ctrl_tb.sv
// self-checking bench for the timer common control block
`timescale 1ns/1ps
module irtc_ctrl_tb;
  import irtc_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0, rd_i = 1'b0, supply_low_i = 1'b0, stop_recover_i = 1'b0;
  logic narrow_timer_raw_i = 1'b0, wide_timer_raw_i = 1'b0, port_data_i = 1'b0;
  logic level = 1'b0, use_alt = 1'b0;
  logic [7:0] rdata_o;
  logic sys_rst_n_o, narrow_timer_init_o, wide_timer_init_o, pingpong_o, demod_mode_o;
  logic wide_timer_output_o, timer_output_pin_o, capture_o, shared_external_interrupt_o;
  logic comparator_capture_pin_i, alternate_capture_pin_i;
  int error_cnt = 0, checked = 0, cap_n = 0, irq_n = 0;
  int c0, i0, n;
  logic [7:0] v, e, r;
  logic a, b, x;

  irtc_ctrl irtc_ctrl_inst (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .supply_low_i(supply_low_i),
    .stop_recover_i(stop_recover_i), .sys_rst_n_o(sys_rst_n_o), .narrow_timer_raw_i(narrow_timer_raw_i),
    .wide_timer_raw_i(wide_timer_raw_i), .port_data_i(port_data_i),
    .narrow_timer_init_o(narrow_timer_init_o), .wide_timer_init_o(wide_timer_init_o),
    .pingpong_o(pingpong_o), .demod_mode_o(demod_mode_o), .wide_timer_output_o(wide_timer_output_o),
    .timer_output_pin_o(timer_output_pin_o), .comparator_capture_pin_i(comparator_capture_pin_i),
    .alternate_capture_pin_i(alternate_capture_pin_i), .capture_o(capture_o),
    .shared_external_interrupt_o(shared_external_interrupt_o));

  irtc_carrier irtc_carrier_inst (.clk_i(clk_i), .level_i(level), .use_alt_i(use_alt),
    .comparator_capture_pin_o(comparator_capture_pin_i), .alternate_capture_pin_o(alternate_capture_pin_i));

  always #10 clk_i = ~clk_i;

  // one-cycle pulses are counted, never polled; mid-cycle so they have settled
  always @(negedge clk_i)
  begin
    if (capture_o === 1'b1)
      cap_n++;
    if (shared_external_interrupt_o === 1'b1)
      irq_n++;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  task automatic reg_wr(input logic [7:0] a_v, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a_v;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a_v, output logic [7:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a_v;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  // bounded wait for the global reset to lift
  task automatic wait_up(output int k);
    k = 0;
    while (sys_rst_n_o !== 1'b1 && k < 400)
    begin
      @(posedge clk_i);
      k++;
    end
  endtask

  task automatic pulse(input int k);
    level <= 1'b1;
    tick(k);
    level <= 1'b0;
    tick(20);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // about 660 cycles expected; thirty times that is a hang
  initial
  begin
    #400000;
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    tick(16);
    nrst_i <= 1'b1;
    wait_up(n);
    check({7'h00, sys_rst_n_o}, 8'h01);
    check({7'h00, n >= POR_CYCLES}, 8'h01);
    reg_rd(ADDR_COMMON_CTL, v);
    check(v, 8'h00);
    reg_wr(ADDR_WIDE_CTL, 8'hA5);
    reg_rd(ADDR_WIDE_CTL, v);
    check(v, 8'hA5);
    reg_wr(8'h05, 8'h3C);
    reg_rd(8'h05, v);
    check(v, 8'h00);
    $display("test reset and map done");
    for (int i = 1; i < 4; i++)
    begin
      reg_wr(ADDR_COMMON_CTL, 8'(i));
      tick(2);
      check({6'h00, narrow_timer_init_o, wide_timer_init_o}, 8'(i));
      reg_rd(ADDR_COMMON_CTL, v);
      check(v, 8'(i));
    end
    // back onto a rising edge before driving inputs directly
    tick(1);
    for (int i = 0; i < 8; i++)
    begin
      wide_timer_raw_i <= i[0];
      reg_wr(ADDR_COMMON_CTL, 8'(i[2:1]) << 2);
      tick(3);
      x = i[2] ? i[1] : i[0];
      check({7'h00, wide_timer_output_o}, {7'h00, x});
      check({7'h00, pingpong_o}, {7'h00, i[2:1] == 2'h1});
    end
    $display("test transmit levels done");
    for (int i = 0; i < 16; i++)
    begin
      a = i[1];
      b = i[0];
      narrow_timer_raw_i <= a;
      wide_timer_raw_i <= b;
      reg_wr(ADDR_COMMON_CTL, 8'h40 | (8'(i[3:2]) << 4));
      tick(3);
      case (i[3:2])
        2'h0: x = a & b;
        2'h1: x = a | b;
        2'h2: x = ~(a | b);
        default: x = ~(a & b);
      endcase
      check({7'h00, timer_output_pin_o}, {7'h00, x});
    end
    reg_wr(ADDR_COMMON_CTL, 8'h30);
    for (int i = 0; i < 2; i++)
    begin
      port_data_i <= ~i[0];
      tick(3);
      check({7'h00, timer_output_pin_o}, {7'h00, ~i[0]});
    end
    narrow_timer_raw_i <= 1'b0;
    wide_timer_raw_i <= 1'b0;
    $display("test combine and pin done");
    for (int i = 0; i < 3; i++)
    begin
      e = 8'h80 | (8'(i) << 4);
      reg_wr(ADDR_COMMON_CTL, e | 8'h03);
      tick(5);
      check({7'h00, demod_mode_o}, 8'h01);
      c0 = cap_n;
      i0 = irq_n;
      pulse(12);
      check(8'(cap_n - c0), (i == 2) ? 8'h02 : 8'h01);
      check(8'(irq_n - i0), (i == 2) ? 8'h02 : 8'h01);
      x = (i != 1);
      v = e | {6'h00, i != 0, x};
      reg_wr(ADDR_COMMON_CTL, e);
      reg_rd(ADDR_COMMON_CTL, r);
      check(r, v);
      // flags stand through a read
      reg_rd(ADDR_COMMON_CTL, r);
      check(r, v);
      reg_wr(ADDR_COMMON_CTL, e | 8'h03);
      reg_rd(ADDR_COMMON_CTL, v);
      check(v, e);
    end
    use_alt <= 1'b1;
    reg_wr(ADDR_COMMON_CTL, 8'hE3);
    tick(5);
    c0 = cap_n;
    i0 = irq_n;
    pulse(12);
    check(8'(cap_n - c0), 8'h02);
    check(8'(irq_n - i0), 8'h00);
    use_alt <= 1'b0;
    $display("test demodulation flags done");
    for (int f = 0; f < 3; f++)
    begin
      reg_wr(ADDR_COMMON_CTL, 8'hA3 | (8'(f) << 2));
      tick(5);
      c0 = cap_n;
      if (f != 0)
      begin
        pulse(4 * f - 1);
        check(8'(cap_n - c0), 8'h00);
      end
      pulse(4 * f + 1);
      check(8'(cap_n - c0), 8'h02);
    end
    $display("test glitch filter done");
    // first write leaves demodulation, only the second sets initial levels
    reg_wr(ADDR_COMMON_CTL, 8'h7F);
    reg_wr(ADDR_COMMON_CTL, 8'h7F);
    @(posedge clk_i);
    stop_recover_i <= 1'b1;
    @(posedge clk_i);
    stop_recover_i <= 1'b0;
    reg_rd(ADDR_COMMON_CTL, v);
    check(v, (8'h7F & ~STOP_RELOAD_MASK) | (COMMON_CTL_RST & STOP_RELOAD_MASK));
    tick(1);
    supply_low_i <= 1'b1;
    tick(5);
    check({7'h00, sys_rst_n_o}, 8'h00);
    tick(40);
    check({7'h00, sys_rst_n_o}, 8'h00);
    supply_low_i <= 1'b0;
    wait_up(n);
    check({7'h00, sys_rst_n_o}, 8'h01);
    check({7'h00, n >= POR_CYCLES}, 8'h01);
    reg_rd(ADDR_COMMON_CTL, v);
    check(v, COMMON_CTL_RST);
    $display("test stop and brown-out done");
    end_of_test();
  end
endmodule // irtc_ctrl_tb
